// ---- hw/inductive_presence_psm.sv ----
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module inductive_presence_psm (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog front end
   input wire logic aux_clk,
   input wire presence_pkg::comp_s comp,
   output logic excite,
   // Host
   output logic presence_out,
   output logic irq
);
   // ---------------------------------
   // Registers
   // ---------------------------------
   logic [7:0] ctrl_q;
   logic [presence_pkg::ST_W-1:0] status_q, status_d;
   logic [presence_pkg::ST_W-1:0] mask_q;
   logic [1:0] state_q;
   logic presence_q;
   logic [7:0] entry_q;
   logic [31:0] prdata_q;
   logic [7:0] psm_q [presence_pkg::PSM_DEPTH];
   presence_pkg::tsm_entry_s [7:0] tsm_q;

   // ---------------------------------
   // Bus decode
   // ---------------------------------
   wire setup_rd = psel && !penable && !pwrite;
   wire wr_en = psel && penable && pwrite;
   wire hit_ctrl = (paddr == presence_pkg::OFF_CTRL);
   wire hit_status = (paddr == presence_pkg::OFF_STATUS);
   wire hit_mask = (paddr == presence_pkg::OFF_MASK);
   wire hit_state = (paddr == presence_pkg::OFF_STATE);
   wire hit_tsm = (paddr[7:5] == presence_pkg::TSM_PAGE) && (paddr[1:0] == 2'b00);
   wire hit_psm = paddr[7] && (paddr[1:0] == 2'b00);
   wire hit_any = hit_ctrl || hit_status || hit_mask || hit_state || hit_tsm || hit_psm;
   wire [2:0] tsm_idx = paddr[4:2];
   wire [4:0] psm_widx = paddr[6:2];
   wire [31:0] state_word = {16'h0000, entry_q, 5'h00, presence_q, state_q};
   wire [31:0] rd_data =
      hit_ctrl ? {24'h000000, ctrl_q} :
      hit_status ? {29'h0, status_q} :
      hit_mask ? {29'h0, mask_q} :
      hit_state ? state_word :
      hit_tsm ? {24'h000000, tsm_q[tsm_idx]} :
      hit_psm ? {24'h000000, psm_q[psm_widx]} : 32'h00000000;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_any;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else if (setup_rd)
         prdata_q <= rd_data;
   end

   // ---------------------------------
   // Control and table storage
   // ---------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= presence_pkg::CTRL_RESET;
         mask_q <= '0;
      end else if (wr_en) begin
         if (hit_ctrl)
            ctrl_q <= pwdata[7:0];
         if (hit_mask)
            mask_q <= pwdata[presence_pkg::ST_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < presence_pkg::PSM_DEPTH; i++)
            psm_q[i] <= presence_pkg::psm_reset(i);
      end else if (wr_en && hit_psm) begin
         psm_q[psm_widx] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsm_q[0] <= presence_pkg::TSM_EXC;
         tsm_q[1] <= presence_pkg::TSM_WAIT;
         tsm_q[2] <= presence_pkg::TSM_SMP;
         for (int i = 3; i < presence_pkg::TSM_DEPTH; i++)
            tsm_q[i] <= presence_pkg::TSM_END;
      end else if (wr_en && hit_tsm) begin
         tsm_q[tsm_idx] <= pwdata[7:0];
      end
   end

   // ---------------------------------
   // Trigger divider
   // ---------------------------------
   wire enabled = ctrl_q[presence_pkg::CTRL_EN];
   wire three_in = ctrl_q[presence_pkg::CTRL_TRI];
   wire [2:0] div_lo = ctrl_q[presence_pkg::CTRL_DLO +: 3];
   wire [2:0] div_hi = ctrl_q[presence_pkg::CTRL_DHI +: 3];
   wire [8:0] ratio = presence_pkg::div_ratio(div_lo, div_hi);
   logic aux_q;
   logic [8:0] div_cnt_q;
   logic trigger_q;
   wire aux_rise = aux_clk && !aux_q;
   wire div_wrap = (div_cnt_q + 9'h001 >= ratio);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_q <= 1'b0;
         div_cnt_q <= 9'h000;
         trigger_q <= 1'b0;
      end else begin
         aux_q <= aux_clk;
         trigger_q <= enabled && aux_rise && div_wrap;
         // Reprogramming restarts the count so a smaller ratio never starts past its end
         if (!enabled)
            div_cnt_q <= 9'h000;
         else if (wr_en && hit_ctrl)
            div_cnt_q <= 9'h000;
         else if (aux_rise)
            div_cnt_q <= div_wrap ? 9'h000 : div_cnt_q + 9'h001;
      end
   end

   // ---------------------------------
   // Timing sequencer
   // ---------------------------------
   logic seq_busy;
   logic seq_done;
   presence_pkg::comp_s sample;

   timing_sequencer u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .start(trigger_q),
      .prog(tsm_q),
      .comp(comp),
      .excite(excite),
      .busy(seq_busy),
      .done(seq_done),
      .sample(sample)
   );

   // ---------------------------------
   // Presence state machine
   // ---------------------------------
   // Third input only counts in three-input mode
   wire in_third = three_in && sample.third;
   wire [4:0] psm_idx = {state_q, in_third, sample.secondary, sample.primary};
   wire [7:0] entry = psm_q[psm_idx];
   wire [1:0] next_state = {entry[presence_pkg::Q_NS_HI], entry[presence_pkg::Q_NS_LO]};
   wire ev_change = seq_done && entry[presence_pkg::Q_CHG];
   wire ev_error = seq_done && entry[presence_pkg::Q_ERR];
   wire [presence_pkg::ST_W-1:0] ev_set = {seq_done, ev_error, ev_change};
   wire [presence_pkg::ST_W-1:0] ev_clr =
      (wr_en && hit_status) ? pwdata[presence_pkg::ST_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= 2'b00;
         presence_q <= 1'b0;
         entry_q <= 8'h00;
      end else if (seq_done) begin
         state_q <= next_state;
         presence_q <= entry[presence_pkg::Q_OUT];
         entry_q <= entry;
      end
   end

   // ---------------------------------
   // Interrupt status
   // ---------------------------------
   // A new event wins over a clear in the same cycle
   assign status_d = (status_q & ~ev_clr) | ev_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         status_q <= '0;
      else
         status_q <= status_d;
   end

   assign irq = |(status_q & mask_q);
   assign presence_out = presence_q;

   // ---------------------------------
   // Checks
   // ---------------------------------
   a_trigger_starts: assert property (@(posedge pclk) disable iff (!presetn)
      trigger_q && !seq_busy |=> seq_busy)
      else $error("trigger did not start the sequencer");
   a_only_trigger: assert property (@(posedge pclk) disable iff (!presetn)
      !seq_busy && !trigger_q |=> !seq_busy)
      else $error("sequencer started without a trigger");
   a_divider_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trigger_q) |-> $past(div_cnt_q) + 9'h001 == $past(ratio))
      else $error("trigger not at the divider ratio");
   a_next_state: assert property (@(posedge pclk) disable iff (!presetn)
      seq_done |=> state_q == {$past(entry[3]), $past(entry[0])} && presence_q == $past(entry[1]))
      else $error("next state or output not taken from entry");
   a_two_inputs: assert property (@(posedge pclk) disable iff (!presetn)
      !three_in |-> psm_idx[2] == 1'b0)
      else $error("third input used in two-input mode");
   a_error_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ev_error |=> status_q[presence_pkg::ST_ERR])
      else $error("error entry did not set status");
   a_change_flag: assert property (@(posedge pclk) disable iff (!presetn)
      seq_done && !entry[6] && !(wr_en && hit_status && pwdata[0]) |=> $stable(status_q[0]))
      else $error("change status moved without a change entry");
   a_change_irq: assert property (@(posedge pclk) disable iff (!presetn)
      ev_change && mask_q[presence_pkg::ST_CHG] && !(wr_en && hit_mask) |=> irq)
      else $error("change entry raised no interrupt");
   a_state_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !seq_done |=> $stable(state_q))
      else $error("state moved without an evaluation");
   a_done_status: assert property (@(posedge pclk) disable iff (!presetn)
      seq_done |=> status_q[presence_pkg::ST_DONE])
      else $error("evaluation did not set the done status");
   a_error_irq: assert property (@(posedge pclk) disable iff (!presetn)
      ev_error && mask_q[presence_pkg::ST_ERR] && !(wr_en && hit_mask) |=> irq)
      else $error("error entry raised no interrupt");
   a_change_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      ev_change |=> status_q[presence_pkg::ST_CHG])
      else $error("change entry lost against a clear");
   a_table_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit_psm |=> psm_q[$past(psm_widx)] == $past(pwdata[7:0]))
      else $error("table write did not land");
   c_change: cover property (@(posedge pclk) disable iff (!presetn) ev_change);
   c_three_in: cover property (@(posedge pclk) disable iff (!presetn) seq_done && in_third);
   c_table_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_psm);
   c_error: cover property (@(posedge pclk) disable iff (!presetn) ev_error);
   c_trigger: cover property (@(posedge pclk) disable iff (!presetn) trigger_q ##[1:40] seq_done);
endmodule

// ---- hw/presence_pkg.sv ----
package presence_pkg;
   // ---------------------------------
   // Register map
   // ---------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MASK = 8'h08;
   localparam logic [7:0] OFF_STATE = 8'h0c;
   localparam logic [2:0] TSM_PAGE = 3'h2;
   localparam int CTRL_EN = 0;
   localparam int CTRL_TRI = 1;
   localparam int CTRL_DLO = 2;
   localparam int CTRL_DHI = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int ST_CHG = 0;
   localparam int ST_ERR = 1;
   localparam int ST_DONE = 2;
   localparam int ST_W = 3;
   // ---------------------------------
   // Table entry bits
   // ---------------------------------
   localparam int Q_NS_LO = 0;
   localparam int Q_OUT = 1;
   localparam int Q_NS_HI = 3;
   localparam int Q_CHG = 6;
   localparam int Q_ERR = 7;
   localparam int PSM_DEPTH = 32;
   localparam int TSM_DEPTH = 8;
   typedef struct packed {
      logic third;
      logic secondary;
      logic primary;
   } comp_s;
   typedef struct packed {
      logic excite;
      logic latch;
      logic stop;
      logic [4:0] dur;
   } tsm_entry_s;
   localparam tsm_entry_s TSM_EXC = '{excite: 1'b1, latch: 1'b0, stop: 1'b0, dur: 5'h0a};
   localparam tsm_entry_s TSM_WAIT = '{excite: 1'b0, latch: 1'b0, stop: 1'b0, dur: 5'h04};
   localparam tsm_entry_s TSM_SMP = '{excite: 1'b0, latch: 1'b1, stop: 1'b0, dur: 5'h02};
   localparam tsm_entry_s TSM_END = '{excite: 1'b0, latch: 1'b0, stop: 1'b1, dur: 5'h00};
   // ---------------------------------
   // Reset contents of the presence table
   // ---------------------------------
   function automatic logic [7:0] psm_reset(input int idx);
      case (idx)
         1: return 8'h43;
         2, 3, 10: return 8'h80;
         8: return 8'h42;
         9: return 8'h01;
         11: return 8'h81;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [8:0] div_ratio(input logic [2:0] lo, input logic [2:0] hi);
      int r;
      r = 2 * (2 * int'(lo) + 1) * (2 * int'(hi) + 1);
      return r[8:0];
   endfunction
endpackage

// ---- hw/timing_sequencer.sv ----
`timescale 1ns/10ps
module timing_sequencer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic start,
   input wire presence_pkg::tsm_entry_s [7:0] prog,
   input wire presence_pkg::comp_s comp,
   // Results
   output logic excite,
   output logic busy,
   output logic done,
   output presence_pkg::comp_s sample
);
   typedef enum logic [2:0] {SEQ_IDLE = 3'b001, SEQ_RUN = 3'b010, SEQ_STOP = 3'b100} seq_e;
   seq_e state_q, state_d;
   logic [2:0] idx_q, idx_d;
   logic [4:0] cnt_q, cnt_d;
   logic excite_q, done_q;
   presence_pkg::comp_s sample_q;
   presence_pkg::tsm_entry_s cur;
   logic last_cycle;
   assign cur = prog[idx_q];
   // Zero duration still takes one period
   assign last_cycle = (cnt_q + 5'h01 >= cur.dur) || (cur.dur == 5'h00);
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      cnt_d = cnt_q;
      case (state_q)
         SEQ_IDLE: begin
            if (start) begin
               idx_d = 3'h0;
               cnt_d = 5'h00;
               state_d = prog[0].stop ? SEQ_STOP : SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            cnt_d = cnt_q + 5'h01;
            if (last_cycle) begin
               cnt_d = 5'h00;
               idx_d = idx_q + 3'h1;
               if (idx_q == 3'h7 || prog[idx_q + 3'h1].stop)
                  state_d = SEQ_STOP;
            end
         end
         SEQ_STOP: state_d = SEQ_IDLE;
         default: state_d = SEQ_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SEQ_IDLE;
         idx_q <= 3'h0;
         cnt_q <= 5'h00;
         excite_q <= 1'b0;
         done_q <= 1'b0;
         sample_q <= '0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         excite_q <= (state_d == SEQ_RUN) && prog[idx_d].excite;
         done_q <= (state_q == SEQ_STOP);
         if (state_q == SEQ_RUN && cur.latch && last_cycle)
            sample_q <= comp;
      end
   end
   assign excite = excite_q;
   assign busy = (state_q != SEQ_IDLE);
   assign done = done_q;
   assign sample = sample_q;
   // ---------------------------------
   // Checks
   // ---------------------------------
   a_stop_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == SEQ_STOP |=> state_q == SEQ_IDLE && done_q)
      else $error("stop state longer than one period");
   a_excite_in_run: assert property (@(posedge pclk) disable iff (!presetn)
      excite_q |-> state_q == SEQ_RUN)
      else $error("excitation outside a running state");
   a_hold_duration: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == SEQ_RUN && cnt_q == 5'h00 && cur.dur > 5'h01) |=> $stable(idx_q))
      else $error("sequencer state left before its duration");
endmodule

// ---- test/lc_sensor_model.sv ----
`timescale 1ns/10ps
// ---------------------------------
// Comparator front end of the sensor
// ---------------------------------
module lc_sensor_model (
   // Clock
   input wire logic pclk,
   // Sensor condition and excitation
   input wire logic excite,
   input wire presence_pkg::comp_s level,
   // Comparator levels
   output presence_pkg::comp_s comp
);
   logic [3:0] win_q = 4'h0;
   logic excite_q = 1'b0;
   logic fall;
   assign fall = excite_q && !excite;
   // Levels settle after the pulse and ring otherwise
   always @(posedge pclk) begin
      excite_q <= excite;
      win_q <= fall ? 4'hc : (win_q != 4'h0) ? win_q - 4'h1 : 4'h0;
      comp <= (fall || win_q != 4'h0) ? level : ~comp;
   end
   initial comp = '0;
endmodule

// ---- test/test_inductive_presence_psm.sv ----
`timescale 1ns/10ps
module test_inductive_presence_psm;
   logic pclk, presetn, psel, penable, pwrite, aux_clk, pready, pslverr, excite, presence_out, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [2:0] aux_cnt;
   presence_pkg::comp_s comp, level;
   int err_count, comparisons, cyc;
   inductive_presence_psm u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .aux_clk(aux_clk), .comp(comp), .excite(excite), .presence_out(presence_out), .irq(irq));
   lc_sensor_model u_sensor (.pclk(pclk), .excite(excite), .level(level), .comp(comp));
   // ---------------------------------
   // Clocks
   // ---------------------------------
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Auxiliary clock at one sixteenth of the bus clock
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      aux_cnt <= aux_cnt + 3'h1;
      if (aux_cnt == 3'h7) begin
         aux_clk <= ~aux_clk;
      end
   end
   // ---------------------------------
   // Helpers
   // ---------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_entry(input logic [3:0] idx);
      case (idx)
         4'h1: return 8'h43;
         4'h2, 4'h3, 4'ha: return 8'h80;
         4'h8: return 8'h42;
         4'h9: return 8'h01;
         4'hb: return 8'h81;
         default: return 8'h00;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n == 64) err_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      check(rd, exp);
   endtask
   task automatic wait_excite(input logic v, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (excite !== v && n < 20000);
      if (n == 20000) err_count++;
   endtask
   task automatic next_run(output int w);
      int n;
      wait_excite(1'b0, n);
      wait_excite(1'b1, n);
      wait_excite(1'b0, w);
      @(posedge pclk);
   endtask
   task automatic eval();
      int w;
      next_run(w);
      repeat (10) @(posedge pclk);
   endtask
   task automatic finish_test();
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #9000000;
      err_count++;
      finish_test();
   end
   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial begin
      int w, t0;
      logic [1:0] inp, st;
      logic [7:0] e;
      logic [2:0] lo, hi;
      logic [4:0] d;
      {presetn, psel, penable, pwrite, aux_clk, aux_cnt, paddr, pwdata, level} = '0;
      {err_count, comparisons, cyc} = '0;
      seed = 32'hc1a2;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h0c, 32'h0);
      check(irq, 1'b0);
      apb(8'h10, 1'b1, 32'hffff_ffff);
      check(err, 1'b1);
      rd_chk(8'h10, 32'h0);
      for (int i = 0; i < 16; i++) begin
         rd_chk(8'h80 + 8'(4 * i), {24'h0, exp_entry(4'(i))});
      end
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         {hi, lo} = (k == 0) ? 6'o00 : (k == 1) ? 6'o13 : (k == 2) ? 6'o77 : seed[5:0];
         apb(8'h00, 1'b1, {24'h0, hi, lo, 2'b01});
         next_run(w);
         t0 = cyc;
         next_run(w);
         check(cyc - t0, 32 * (2 * int'(lo) + 1) * (2 * int'(hi) + 1));
      end
      apb(8'h00, 1'b1, 32'h05);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         d = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : seed[4:0];
         apb(8'h40, 1'b1, {24'h0, 3'b100, d});
         next_run(w);
         next_run(w);
         check(w, (d == 5'h0) ? 1 : int'(d));
      end
      apb(8'h40, 1'b1, 32'h8a);
      eval();
      apb(8'h04, 1'b1, 32'h7);
      st = 2'b00;
      for (int k = 0; k < 16; k++) begin
         seed = lfsr(seed);
         inp = (k < 6) ? 2'(12'h2d1 >> (2 * k)) : seed[1:0];
         level <= {seed[2], inp};
         apb(8'h08, 1'b1, k[0] ? 32'h0 : 32'h3);
         eval();
         e = exp_entry({st, 1'b0, inp});
         st = {e[3], e[0]};
         rd_chk(8'h0c, {16'h0, e, 5'h0, e[1], st});
         rd_chk(8'h04, {29'h0, 1'b1, e[7], e[6]});
         check(irq, (e[7] | e[6]) && !k[0]);
         check(presence_out, e[1]);
         apb(8'h04, 1'b1, 32'h7);
         check(irq, 1'b0);
      end
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      level <= '0;
      @(posedge pclk);
      rd_chk(8'h0c, 32'h0);
      apb(8'h80, 1'b1, 32'h43);
      apb(8'h00, 1'b1, 32'h05);
      eval();
      rd_chk(8'h0c, 32'h4305);
      apb(8'hb0, 1'b1, 32'h81);
      apb(8'h00, 1'b1, 32'h07);
      level <= 3'b100;
      eval();
      rd_chk(8'h0c, 32'h8101);
      finish_test();
   end
endmodule
